/* File: rtl/dsg_pkg.sv */
// Purpose: Shared constants and types for deep-sleep gating and soft reset
// Assumes: 32-bit register port, byte offsets as printed
// Notes:   Referenced by dsg_top and dsg_cap_mask
package dsg_pkg;
   localparam int DW = 32;
   localparam int AW = 12;

   // ==========================================================
   // Register offsets
   localparam logic [AW-1:0] OFS_SRC_A     = 12'h040;
   localparam logic [AW-1:0] OFS_SRC_B     = 12'h044;
   localparam logic [AW-1:0] OFS_RUN_GATE  = 12'h108;
   localparam logic [AW-1:0] OFS_SLP_GATE  = 12'h118;
   localparam logic [AW-1:0] OFS_DS_GATE   = 12'h128;
   localparam logic [AW-1:0] OFS_RUN_CFG   = 12'h060;
   localparam logic [AW-1:0] OFS_IRQ_STAT  = 12'h200;
   localparam logic [AW-1:0] OFS_IRQ_MASK  = 12'h204;

   // ==========================================================
   // Field layouts and reset values
   localparam int NPORT = 3;
   localparam logic [DW-1:0] GATE_MASK  = 32'h0000_0007;
   localparam logic [DW-1:0] SRC_A_MASK = 32'h0000_0008;
   localparam logic [DW-1:0] SRC_B_MASK = 32'h0303_0011;
   localparam logic [DW-1:0] REG_RST    = 32'h0000_0000;
   localparam int BIT_AUTO_GATE = 0;
   localparam int BIT_WATCHDOG  = 3;
   localparam int BIT_CMP_ONE   = 25;
   localparam int BIT_CMP_ZERO  = 24;
   localparam int BIT_TMR_ONE   = 17;
   localparam int BIT_TMR_ZERO  = 16;
   localparam int BIT_SYNC_SER  = 4;
   localparam int BIT_ASYNC_SER = 0;

   // Interrupt status bits
   localparam int IRQ_N         = 3;
   localparam int IRQ_FAULT     = 0;
   localparam int IRQ_MODE_CHG  = 1;
   localparam int IRQ_RST_ASSRT = 2;

   typedef enum logic [1:0] {
      DSG_RUN,
      DSG_SLEEP,
      DSG_DEEP
   } dsg_mode_t;

   typedef struct packed {
      logic            wr;
      logic            rd;
      logic [AW-1:0]   addr;
      logic [DW-1:0]   wdata;
   } dsg_bus_req_t;

   typedef struct packed {
      logic            watchdog_reset_ctl;
      logic            comparator_one_reset;
      logic            comparator_zero_reset;
      logic            gp_timer_one_reset;
      logic            gp_timer_zero_reset;
      logic            sync_serial_zero_reset;
      logic            async_serial_zero_reset;
   } dsg_periph_rst_t;
endpackage

/* File: rtl/dsg_cap_mask.sv */
// Purpose: Masked register update for capability-gated soft reset bits
// Assumes: Capability bit 1 means the unit is present
// Notes:   Only bits set in both the field mask and capability mask move
`timescale 1ns/100ps
module dsg_cap_mask
   import dsg_pkg::*;
#(
   parameter logic [DW-1:0] FIELD = REG_RST
) (
   input  wire logic [DW-1:0] cur,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [DW-1:0] cap,
   output logic      [DW-1:0] nxt
);
   logic [DW-1:0] keep;

   assign keep = FIELD & cap;
   // Bits of absent units hold their value, which is zero from reset
   assign nxt  = (wdata & keep) | (cur & ~keep);
endmodule

/* File: rtl/dsg_top.sv */
// Purpose: Deep-sleep port clock gating plus two software reset registers
// Assumes: Simple strobe register port; read data one cycle after strobe
// Notes:   Gate enables are levels meant for a glitch-free clock gate cell
//
// Functional notes
// [R1] Port clock enable follows its gating bit; zero leaves port unclocked.
// [R2] Access to a port whose clock is off returns a bus fault.
// [R3] All gating bits reset to zero so ports start unclocked.
// [R4] Deep-sleep gating register holds port C bit 2, B bit 1, A bit 0.
// [R5] Reserved bits are read-only and read as zero.
// [R6] Deep-sleep gating set acts only while processor is in deep-sleep.
// [R7] Sleep sets apply only with auto gating select set; else run set.
// [R8] Soft reset writes are masked by the matching capability register.
// [R9] First soft reset register: watchdog at bit 3, rest reserved, resets zero.
// [R10] Second soft reset register: comparator one bit 25, zero bit 24.
// [R11] Second soft reset register: timer one bit 17, timer zero bit 16.
// [R12] Second soft reset register: serial sync bit 4, UART bit 0.
// [R13] A set soft reset bit holds its peripheral in reset until cleared.
`timescale 1ns/100ps
module dsg_top
   import dsg_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            rstn,
   // Register port
   input  wire logic [AW-1:0]   reg_addr,
   input  wire logic [DW-1:0]   reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic      [DW-1:0]   reg_rdata,
   // Processor power state
   input  wire logic            cpu_sleep,
   input  wire logic            cpu_deep_sleep,
   // Capability registers, one bit per present unit
   input  wire logic [DW-1:0]   capability_reg_one,
   input  wire logic [DW-1:0]   capability_reg_two,
   // Peripheral bus accesses aimed at the ports
   input  wire logic [NPORT-1:0] port_access,
   output logic                 port_bus_fault,
   // Outputs to the clock tree and peripheral resets, plus gating mode and interrupt
   output logic      [NPORT-1:0] port_clk_en,
   output dsg_periph_rst_t      periph_rst,
   output dsg_mode_t            gate_mode,
   output logic                 irq
);
   // ==========================================================
   // Register state
   logic [NPORT-1:0] run_gate_q;
   logic [NPORT-1:0] slp_gate_q;
   logic [NPORT-1:0] ds_gate_q;
   logic             auto_gate_q;
   logic [DW-1:0]    src_a_q;
   logic [DW-1:0]    src_b_q;
   logic [DW-1:0]    src_a_d;
   logic [DW-1:0]    src_b_d;
   logic [IRQ_N-1:0] irq_stat_q;
   logic [IRQ_N-1:0] irq_mask_q;
   logic [IRQ_N-1:0] irq_evt;
   logic [DW-1:0]    rdata_d;
   logic [DW-1:0]    rdata_q;
   logic             fault_q;
   dsg_mode_t        mode_q;
   dsg_mode_t        mode_d;
   dsg_bus_req_t     req;
   logic [NPORT-1:0] gate_sel;
   logic             wr_src_a;
   logic             wr_src_b;

   assign req.wr    = reg_wr;
   assign req.rd    = reg_rd;
   assign req.addr  = reg_addr;
   assign req.wdata = reg_wdata;

   assign wr_src_a = req.wr && (req.addr == OFS_SRC_A);
   assign wr_src_b = req.wr && (req.addr == OFS_SRC_B);

   // ==========================================================
   // Gating registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         run_gate_q <= REG_RST[NPORT-1:0]; // R3
         slp_gate_q <= REG_RST[NPORT-1:0]; // R3
         ds_gate_q  <= REG_RST[NPORT-1:0]; // R3
      end else if (req.wr) begin
         unique case (req.addr)
            OFS_RUN_GATE: run_gate_q <= req.wdata[NPORT-1:0];
            OFS_SLP_GATE: slp_gate_q <= req.wdata[NPORT-1:0];
            OFS_DS_GATE:  ds_gate_q  <= req.wdata[NPORT-1:0]; // R4
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         auto_gate_q <= REG_RST[BIT_AUTO_GATE];
      end else if (req.wr && req.addr == OFS_RUN_CFG) begin
         auto_gate_q <= req.wdata[BIT_AUTO_GATE];
      end
   end

   // ==========================================================
   // Mode select: deep-sleep wins over sleep
   always_comb begin
      mode_d = DSG_RUN;
      if (auto_gate_q) begin // R7
         if (cpu_deep_sleep) begin
            mode_d = DSG_DEEP; // R6
         end else if (cpu_sleep) begin
            mode_d = DSG_SLEEP;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_q <= DSG_RUN;
      end else begin
         mode_q <= mode_d;
      end
   end

   always_comb begin
      unique case (mode_q)
         DSG_SLEEP: gate_sel = slp_gate_q; // R7
         DSG_DEEP:  gate_sel = ds_gate_q;  // R6
         default:   gate_sel = run_gate_q;
      endcase
   end

   // Registered enable keeps the clock gate input free of decode glitches
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         port_clk_en <= '0;
      end else begin
         port_clk_en <= gate_sel; // R1
      end
   end

   // ==========================================================
   // Bus fault for accesses to unclocked ports
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= |(port_access & ~port_clk_en); // R2
      end
   end
   assign port_bus_fault = fault_q;

   // ==========================================================
   // Soft reset registers, writes masked by capability
   dsg_cap_mask #(
      .FIELD (SRC_A_MASK)
   ) u_mask_a (
      .cur   (src_a_q),
      .wdata (req.wdata),
      .cap   (capability_reg_one), // R8
      .nxt   (src_a_d)
   );

   dsg_cap_mask #(
      .FIELD (SRC_B_MASK)
   ) u_mask_b (
      .cur   (src_b_q),
      .wdata (req.wdata),
      .cap   (capability_reg_two), // R8
      .nxt   (src_b_d)
   );

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         src_a_q <= REG_RST; // R9
      end else if (wr_src_a) begin
         src_a_q <= src_a_d & SRC_A_MASK; // R9
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         src_b_q <= REG_RST;
      end else if (wr_src_b) begin
         src_b_q <= src_b_d & SRC_B_MASK; // R10 R11 R12
      end
   end

   // Reset levels follow the stored bits one clock later, through a register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         periph_rst <= '0;
      end else begin
         periph_rst.watchdog_reset_ctl      <= src_a_q[BIT_WATCHDOG];  // R13
         periph_rst.comparator_one_reset    <= src_b_q[BIT_CMP_ONE];   // R13
         periph_rst.comparator_zero_reset   <= src_b_q[BIT_CMP_ZERO];  // R13
         periph_rst.gp_timer_one_reset      <= src_b_q[BIT_TMR_ONE];   // R13
         periph_rst.gp_timer_zero_reset     <= src_b_q[BIT_TMR_ZERO];  // R13
         periph_rst.sync_serial_zero_reset  <= src_b_q[BIT_SYNC_SER];  // R13
         periph_rst.async_serial_zero_reset <= src_b_q[BIT_ASYNC_SER]; // R13
      end
   end
   assign gate_mode = mode_q;

   // ==========================================================
   // Interrupt status: set wins over read clear
   assign irq_evt[IRQ_FAULT]     = fault_q;
   assign irq_evt[IRQ_MODE_CHG]  = (mode_d != mode_q);
   assign irq_evt[IRQ_RST_ASSRT] = (wr_src_a && |(src_a_d & SRC_A_MASK & ~src_a_q))
                                 || (wr_src_b && |(src_b_d & SRC_B_MASK & ~src_b_q));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_stat_q <= '0;
      end else if (req.rd && req.addr == OFS_IRQ_STAT) begin
         irq_stat_q <= irq_evt;
      end else begin
         irq_stat_q <= irq_stat_q | irq_evt;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_mask_q <= '0;
      end else if (req.wr && req.addr == OFS_IRQ_MASK) begin
         irq_mask_q <= req.wdata[IRQ_N-1:0];
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   // ==========================================================
   // Read path; reserved and unmapped bits read zero
   always_comb begin
      rdata_d = '0;
      unique case (req.addr)
         OFS_SRC_A:    rdata_d = src_a_q & SRC_A_MASK; // R5
         OFS_SRC_B:    rdata_d = src_b_q & SRC_B_MASK; // R5
         OFS_RUN_GATE: rdata_d[NPORT-1:0] = run_gate_q;
         OFS_SLP_GATE: rdata_d[NPORT-1:0] = slp_gate_q;
         OFS_DS_GATE:  rdata_d[NPORT-1:0] = ds_gate_q; // R5
         OFS_RUN_CFG:  rdata_d[BIT_AUTO_GATE] = auto_gate_q;
         OFS_IRQ_STAT: rdata_d[IRQ_N-1:0] = irq_stat_q;
         OFS_IRQ_MASK: rdata_d[IRQ_N-1:0] = irq_mask_q;
         default:      rdata_d = '0;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= '0;
      end else if (req.rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= '0;
      end
   end
   assign reg_rdata = rdata_q;
endmodule

/* File: testbench/dsg_top_asserts.sv */
// Purpose: Port-level checks for dsg_top
// Assumes: Strobe register port, single clock
// Notes:   Bound into every dsg_top instance
`timescale 1ns/100ps
module dsg_top_asserts
   import dsg_pkg::*;
(
   input wire logic             clk,
   input wire logic             rstn,
   input wire logic [AW-1:0]    reg_addr,
   input wire logic [DW-1:0]    reg_wdata,
   input wire logic             reg_wr,
   input wire logic             reg_rd,
   input wire logic [DW-1:0]    reg_rdata,
   input wire logic             cpu_sleep,
   input wire logic             cpu_deep_sleep,
   input wire logic [DW-1:0]    capability_reg_one,
   input wire logic [DW-1:0]    capability_reg_two,
   input wire logic [NPORT-1:0] port_access,
   input wire logic             port_bus_fault,
   input wire logic [NPORT-1:0] port_clk_en,
   input wire dsg_periph_rst_t  periph_rst,
   input wire dsg_mode_t        gate_mode,
   input wire logic             irq
);
   logic bad_acc;
   assign bad_acc = |(port_access & ~port_clk_en);
   // ==========================================================
   // Properties
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   ds_rsvd_a: assert property (reg_rd && reg_addr == OFS_DS_GATE |=>
      (reg_rdata & ~GATE_MASK) == 32'h0) else $error("reserved gate bits not zero");
   fault_raise_a: assert property (bad_acc |=> port_bus_fault)
      else $error("no fault on gated port access");
   fault_cause_a: assert property (port_bus_fault |-> $past(bad_acc))
      else $error("fault without gated access");
   run_mode_a: assert property (!$past(cpu_sleep) && !$past(cpu_deep_sleep) |->
      gate_mode == DSG_RUN) else $error("gate mode not run while awake");
   deep_only_a: assert property (gate_mode == DSG_DEEP |-> $past(cpu_deep_sleep))
      else $error("deep set used outside deep sleep");
   sleep_only_a: assert property (gate_mode == DSG_SLEEP |->
      $past(cpu_sleep) && !$past(cpu_deep_sleep)) else $error("sleep set misused");
   srca_clear_a: assert property (reg_wr && reg_addr == OFS_SRC_A && !reg_wdata[3]
      && capability_reg_one[3] |-> ##2 !periph_rst[6]) else $error("reset a not released");
   srcb_clear_a: assert property (reg_wr && reg_addr == OFS_SRC_B && reg_wdata == 32'h0
      && capability_reg_two == '1 |-> ##2 periph_rst[5:0] == 6'h0)
      else $error("reset b not released");
endmodule

bind dsg_top dsg_top_asserts dsg_top_asserts_i (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .cpu_sleep, .cpu_deep_sleep, .capability_reg_one,
   .capability_reg_two, .port_access, .port_bus_fault, .port_clk_en, .periph_rst,
   .gate_mode, .irq);

/* File: testbench/dsg_top_test.sv */
// Purpose: Self-checking bench for dsg_top
// Assumes: Read data stand one cycle after the strobe
// Notes:   Directed scenarios only
`timescale 1ns/100ps
module dsg_top_test
   import dsg_pkg::*;
();
   logic             clk = 1'b0;
   logic             rstn = 1'b0;
   logic [AW-1:0]    reg_addr = '0;
   logic [DW-1:0]    reg_wdata = '0;
   logic             reg_wr = 1'b0;
   logic             reg_rd = 1'b0;
   logic [DW-1:0]    reg_rdata;
   logic             cpu_sleep = 1'b0;
   logic             cpu_deep_sleep = 1'b0;
   logic [DW-1:0]    capability_reg_one = '1;
   logic [DW-1:0]    capability_reg_two = '1;
   logic [NPORT-1:0] port_access = '0;
   logic             port_bus_fault;
   logic [NPORT-1:0] port_clk_en;
   dsg_periph_rst_t  periph_rst;
   dsg_mode_t        gate_mode;
   logic             irq;
   int               num_errors = 0;
   int               n_compared = 0;
   int               cycles = 0;
   always #2 clk = ~clk;
   dsg_top dsg_top_i (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .cpu_sleep, .cpu_deep_sleep, .capability_reg_one, .capability_reg_two, .port_access,
      .port_bus_fault, .port_clk_en, .periph_rst, .gate_mode, .irq);
   // ==========================================================
   // Bus and compare helpers
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(logic [AW-1:0] a, logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Leaves just after the edge that launches the data
   task automatic rd(logic [AW-1:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic acc(logic [2:0] p, logic f);
      @(posedge clk);
      port_access <= p;
      @(posedge clk);
      port_access <= 3'h0;
      #1;
      chk("fault", {31'h0, f}, {31'h0, port_bus_fault});
   endtask
   task automatic en(logic [2:0] e);
      chk("clk en", {29'h0, e}, {29'h0, port_clk_en});
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      rd(OFS_DS_GATE);
      chk("ds gate", 32'h0, reg_rdata);
      rd(OFS_SRC_A);
      chk("src a", 32'h0, reg_rdata);
      en(3'h0);
      wr(12'h3fc, 32'hffff_ffff);
      rd(12'h3fc);
      chk("unmapped", 32'h0, reg_rdata);
   endtask
   task automatic t_gate();
      wr(OFS_DS_GATE, 32'hffff_ffff);
      wr(OFS_RUN_GATE, 32'h3);
      rd(OFS_DS_GATE);
      chk("ds gate rw", 32'h7, reg_rdata);
      wr(OFS_RUN_CFG, 32'h1);
      @(posedge clk);
      cpu_deep_sleep <= 1'b1;
      cyc(3);
      en(3'h7);
      wr(OFS_DS_GATE, 32'h5);
      cyc(2);
      en(3'h5);
      acc(3'h2, 1'b1);
      acc(3'h1, 1'b0);
      wr(OFS_SLP_GATE, 32'h6);
      @(posedge clk);
      cpu_deep_sleep <= 1'b0;
      cpu_sleep <= 1'b1;
      cyc(3);
      en(3'h6);
      wr(OFS_RUN_CFG, 32'h0);
      cyc(3);
      en(3'h3);
      @(posedge clk);
      cpu_sleep <= 1'b0;
   endtask
   task automatic t_soft();
      wr(OFS_SRC_A, 32'hffff_ffff);
      rd(OFS_SRC_A);
      chk("src a rw", 32'h8, reg_rdata);
      chk("rst a", 32'h40, {25'h0, periph_rst});
      wr(OFS_SRC_B, 32'hffff_ffff);
      rd(OFS_SRC_B);
      chk("src b rw", 32'h0303_0011, reg_rdata);
      chk("rst b", 32'h7f, {25'h0, periph_rst});
      wr(OFS_SRC_A, 32'h0);
      wr(OFS_SRC_B, 32'h0);
      cyc(2);
      chk("rst off", 32'h0, {25'h0, periph_rst});
      @(posedge clk);
      capability_reg_one <= 32'h0;
      capability_reg_two <= 32'h0100_0000;
      wr(OFS_SRC_A, 32'hffff_ffff);
      wr(OFS_SRC_B, 32'hffff_ffff);
      rd(OFS_SRC_A);
      chk("masked a", 32'h0, reg_rdata);
      rd(OFS_SRC_B);
      chk("masked b", 32'h0100_0000, reg_rdata);
   endtask
   task automatic t_irq();
      wr(OFS_IRQ_MASK, 32'h0);
      rd(OFS_IRQ_STAT);
      acc(3'h4, 1'b1);
      cyc(1);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(OFS_IRQ_MASK, 32'h1);
      #1;
      chk("irq up", 32'h1, {31'h0, irq});
      rd(OFS_IRQ_STAT);
      chk("status", 32'h1, reg_rdata);
      chk("irq clear", 32'h0, {31'h0, irq});
   endtask
   // ==========================================================
   // Run control
   task automatic finish_test();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         finish_test();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_gate();
      t_soft();
      t_irq();
      finish_test();
   end
endmodule
